//--- rtl/sra_serial_access.sv
// Serial command interpreter with register access, continuous read and ones-reset
//
// Function
// - Gate bit 1 holds at first position
// - Gate bit 0 loads next seven bits
// - Mode bits: write, read, start, stop
// - Single write, then await command
// - Single read, then await command
// - Continuous read repeats without new command
// - Continuous read ends on code 30h
// - Stop code or thirty-two ones end continuous read
// - Input sampled every clock during continuous
// - Three select bits choose target register
// - Status read-only, resets to Cx
// - Status shifted out MSB first
// - Command MSB arrives first
// - Reset leaves interface awaiting command
// - Thirty-two ones reset the interface
`timescale 1ns/1ps
module sra_serial_access #(
  parameter logic [3:0] STATUS_RESET_LO = 4'h0
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic din,
  input wire logic [7:0] status_in,
  input wire logic [23:0] reg_read_data,
  output logic dout,
  output logic dout_en,
  output logic wr_strobe,
  output sra_pkg::sra_wr_s wr_req,
  output logic rd_strobe,
  output logic [2:0] rd_target,
  output logic device_reset
);
  import sra_pkg::*;

  // Number of bits shifted for a target
  function automatic logic [4:0] target_bits(input logic [2:0] tgt);
    unique case (tgt)
      TGT_CMD_STATUS, TGT_DAC: target_bits = BITS_BYTE;
      TGT_MODE: target_bits = BITS_HALF;
      default: target_bits = BITS_WORD;
    endcase
  endfunction : target_bits

  // ********************************
  // Link domain reset
  // ********************************
  // The link clock may stop between frames, so the host must give a few edges after reset
  logic lrst_s1;
  logic lrst_s2;
  logic lrst_s3;
  logic link_reset;

  always_ff @(posedge sclk)
  begin
    lrst_s1 <= reset;
    lrst_s2 <= lrst_s1;
    lrst_s3 <= lrst_s2;
  end
  assign link_reset = lrst_s2 & lrst_s3;

  // ********************************
  // Link domain: command and shift
  // ********************************
  sra_state_e state;
  logic [4:0] bit_cnt;
  logic [6:0] cmd_sr;
  logic [7:0] command_register;
  logic [23:0] wr_sr;
  logic [23:0] wr_word;
  logic [23:0] rd_sr;
  logic [4:0] ones_cnt;
  logic [7:0] sniff;
  logic [2:0] sniff_cnt;
  logic rd_tgl;
  logic wr_tgl;
  logic rst_tgl;
  logic [7:0] next_cmd;
  logic [4:0] width;
  logic last_bit;
  logic ones_reset;
  logic stop_seen;
  logic [23:0] rd_hold;

  assign next_cmd = {1'b0, cmd_sr[5:0], din};
  assign width = target_bits(command_register[CMD_TGT_HI:CMD_TGT_LO]);
  assign last_bit = (bit_cnt == width - 5'h01);
  assign ones_reset = din && (ones_cnt == ONES_RESET_LAST);
  assign stop_seen = (sniff_cnt == SNIFF_LAST) && ({sniff[6:0], din} == STOP_CONT_CODE);

  // Runs of ones, counted in every state
  always_ff @(posedge sclk)
  begin
    if (link_reset || ones_reset)
      ones_cnt <= 5'h00;
    else if (din)
      ones_cnt <= ones_cnt + 5'h01;
    else
      ones_cnt <= 5'h00;
  end

  always_ff @(posedge sclk)
  begin
    if (link_reset)
      rst_tgl <= 1'b0;
    else if (ones_reset)
      rst_tgl <= ~rst_tgl;
  end

  always_ff @(posedge sclk)
  begin
    if (link_reset || ones_reset)
    begin
      state <= SRA_CMD;
      bit_cnt <= 5'h00;
      cmd_sr <= 7'h00;
      command_register <= 8'h00;
    end
    else
    begin
      unique case (state)
        SRA_CMD:
        begin
          if (bit_cnt == 5'h00)
          begin
            if (!din)
              bit_cnt <= 5'h01;
          end
          else
          begin
            cmd_sr <= {cmd_sr[5:0], din};
            if (bit_cnt == 5'(CMD_LAST_POS))
            begin
              command_register <= next_cmd;
              bit_cnt <= 5'h00;
              unique case (next_cmd[CMD_MODE_HI:CMD_MODE_LO])
                MODE_SINGLE_WRITE:
                  // A write to the command register is simply the next command byte
                  state <= (next_cmd[CMD_TGT_HI:CMD_TGT_LO] == TGT_CMD_STATUS) ? SRA_CMD : SRA_WRITE;
                MODE_SINGLE_READ: state <= SRA_READ;
                MODE_CONT_START: state <= SRA_CONT;
                MODE_CONT_STOP: state <= SRA_CMD;
              endcase
            end
            else
              bit_cnt <= bit_cnt + 5'h01;
          end
        end
        SRA_WRITE, SRA_READ:
        begin
          if (last_bit)
          begin
            bit_cnt <= 5'h00;
            state <= SRA_CMD;
          end
          else
            bit_cnt <= bit_cnt + 5'h01;
        end
        SRA_CONT:
        begin
          if (stop_seen)
          begin
            bit_cnt <= 5'h00;
            state <= SRA_CMD;
          end
          else if (last_bit)
            bit_cnt <= 5'h00;
          else
            bit_cnt <= bit_cnt + 5'h01;
        end
      endcase
    end
  end

  // Stop-code watch, aligned to byte boundaries from entry into continuous read
  always_ff @(posedge sclk)
  begin
    if (link_reset || state != SRA_CONT)
    begin
      sniff <= 8'h00;
      sniff_cnt <= 3'h0;
    end
    else
    begin
      sniff <= {sniff[6:0], din};
      sniff_cnt <= sniff_cnt + 3'h1;
    end
  end

  always_ff @(posedge sclk)
  begin
    if (link_reset)
    begin
      wr_sr <= WORD_ZERO;
      wr_word <= WORD_ZERO;
      wr_tgl <= 1'b0;
    end
    else if (state == SRA_WRITE)
    begin
      wr_sr <= {wr_sr[22:0], din};
      if (last_bit)
      begin
        wr_word <= {wr_sr[22:0], din};
        wr_tgl <= ~wr_tgl;
      end
    end
    else
      // Cleared between writes so a short word is handed over right-aligned with no stale upper bits
      wr_sr <= WORD_ZERO;
  end

  // A read request goes out with each command that reads and after each continuous word
  always_ff @(posedge sclk)
  begin
    if (link_reset)
      rd_tgl <= 1'b0;
    else if (state == SRA_CMD && bit_cnt == 5'(CMD_LAST_POS) && !ones_reset
             && (next_cmd[CMD_MODE_HI:CMD_MODE_LO] == MODE_SINGLE_READ
                 || next_cmd[CMD_MODE_HI:CMD_MODE_LO] == MODE_CONT_START))
      rd_tgl <= ~rd_tgl;
    else if (state == SRA_CONT && last_bit && !stop_seen && !ones_reset)
      rd_tgl <= ~rd_tgl;
  end

  // The hold word is quasi-static: the host gap after a request lets it settle before use
  always_ff @(posedge sclk)
  begin
    if (link_reset)
      rd_sr <= WORD_ZERO;
    else if ((state == SRA_READ || state == SRA_CONT) && bit_cnt == 5'h00)
      rd_sr <= {rd_hold[22:0], 1'b0};
    else
      rd_sr <= {rd_sr[22:0], 1'b0};
  end

  // Data changes on the falling edge so the host samples it on the rising edge
  always_ff @(negedge sclk)
  begin
    if (link_reset)
    begin
      dout <= 1'b0;
      dout_en <= 1'b0;
    end
    else
    begin
      dout_en <= (state == SRA_READ || state == SRA_CONT);
      dout <= (bit_cnt == 5'h00) ? rd_hold[WORD_W-1] : rd_sr[WORD_W-1];
    end
  end

  // ********************************
  // System domain
  // ********************************
  logic [2:0] rd_sync;
  logic [2:0] wr_sync;
  logic [2:0] rst_sync;
  logic [7:0] status_byte;
  logic rd_pending;
  logic [2:0] cmd_tgt_sys;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd_sync <= 3'h0;
      wr_sync <= 3'h0;
      rst_sync <= 3'h0;
    end
    else
    begin
      rd_sync <= {rd_sync[1:0], rd_tgl};
      wr_sync <= {wr_sync[1:0], wr_tgl};
      rst_sync <= {rst_sync[1:0], rst_tgl};
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      status_byte <= {STATUS_RESET_HI, STATUS_RESET_LO};
    else
      status_byte <= status_in;
  end

  // Target field is stable while a read is outstanding
  assign cmd_tgt_sys = command_register[CMD_TGT_HI:CMD_TGT_LO];

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd_strobe <= 1'b0;
      rd_target <= 3'h0;
      rd_pending <= 1'b0;
      rd_hold <= WORD_ZERO;
    end
    else
    begin
      rd_strobe <= 1'b0;
      rd_pending <= 1'b0;
      if (rd_sync[2] != rd_sync[1])
      begin
        rd_target <= cmd_tgt_sys;
        rd_strobe <= (cmd_tgt_sys != TGT_CMD_STATUS);
        rd_pending <= 1'b1;
        if (cmd_tgt_sys == TGT_CMD_STATUS)
          rd_hold <= {status_byte, 16'h0000};
      end
      if (rd_pending && rd_target != TGT_CMD_STATUS)
      begin
        unique case (target_bits(rd_target))
          BITS_BYTE: rd_hold <= {reg_read_data[7:0], 16'h0000};
          BITS_HALF: rd_hold <= {reg_read_data[15:0], 8'h00};
          default: rd_hold <= reg_read_data;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_strobe <= 1'b0;
      wr_req <= '0;
    end
    else
    begin
      wr_strobe <= (wr_sync[2] != wr_sync[1]);
      if (wr_sync[2] != wr_sync[1])
        wr_req <= '{target: cmd_tgt_sys, data: wr_word};
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      device_reset <= 1'b0;
    else
      device_reset <= (rst_sync[2] != rst_sync[1]);
  end

  // ********************************
  // Checks
  // ********************************
  property p_gate_hold;
    @(posedge sclk) disable iff (link_reset)
    (state == SRA_CMD && bit_cnt == 5'h00 && din && !ones_reset) |=> (state == SRA_CMD && bit_cnt == 5'h00);
  endproperty
  a_gate_hold : assert property (p_gate_hold) else $error("gate bit one did not hold");

  property p_cmd_load;
    @(posedge sclk) disable iff (link_reset)
    (state == SRA_CMD && bit_cnt == 5'(CMD_LAST_POS) && !ones_reset) |=> (command_register == $past(next_cmd));
  endproperty
  a_cmd_load : assert property (p_cmd_load) else $error("command byte not loaded");

  property p_mode_decode;
    @(posedge sclk) disable iff (link_reset)
    (state == SRA_CMD && bit_cnt == 5'(CMD_LAST_POS) && !ones_reset
     && next_cmd[CMD_MODE_HI:CMD_MODE_LO] == MODE_SINGLE_READ) |=> (state == SRA_READ);
  endproperty
  a_mode_decode : assert property (p_mode_decode) else $error("read mode not entered");

  property p_single_return;
    @(posedge sclk) disable iff (link_reset)
    ((state == SRA_READ || state == SRA_WRITE) && bit_cnt == 5'h00) |->
      ##1 (state == SRA_READ || state == SRA_WRITE || state == SRA_CMD)[*1] ##[1:23] (state == SRA_CMD);
  endproperty
  a_single_return : assert property (p_single_return) else $error("single access did not return");

  property p_cont_stays;
    @(posedge sclk) disable iff (link_reset)
    (state == SRA_CONT && last_bit && !stop_seen && !ones_reset) |=> (state == SRA_CONT && bit_cnt == 5'h00);
  endproperty
  a_cont_stays : assert property (p_cont_stays) else $error("continuous read left early");

  property p_stop_code;
    @(posedge sclk) disable iff (link_reset)
    (state == SRA_CONT && stop_seen) |=> (state == SRA_CMD && bit_cnt == 5'h00);
  endproperty
  a_stop_code : assert property (p_stop_code) else $error("stop code ignored");

  property p_ones_reset;
    @(posedge sclk) disable iff (link_reset)
    ones_reset |=> (state == SRA_CMD && ones_cnt == 5'h00 && rst_tgl != $past(rst_tgl));
  endproperty
  a_ones_reset : assert property (p_ones_reset) else $error("ones run did not reset");

  property p_write_strobe;
    @(posedge clk) disable iff (reset)
    (wr_sync[2] != wr_sync[1]) |=> (wr_strobe && wr_req.data == $past(wr_word));
  endproperty
  a_write_strobe : assert property (p_write_strobe) else $error("write not delivered");

  property p_status_read;
    @(posedge clk) disable iff (reset)
    (rd_sync[2] != rd_sync[1] && cmd_tgt_sys == TGT_CMD_STATUS) |=> (rd_hold[23:16] == $past(status_byte) && !rd_strobe);
  endproperty
  a_status_read : assert property (p_status_read) else $error("status byte not staged");

endmodule : sra_serial_access

//--- rtl/sra_pkg.sv
// Package: constants and carriers for the serial register access front end
package sra_pkg;

  // ********************************
  // Command byte layout
  // ********************************
  localparam int CMD_GATE_BIT = 7;
  localparam int CMD_MODE_HI = 5;
  localparam int CMD_MODE_LO = 4;
  localparam int CMD_TGT_HI = 2;
  localparam int CMD_TGT_LO = 0;
  localparam int CMD_LAST_POS = 7;

  localparam logic [1:0] MODE_SINGLE_WRITE = 2'h0;
  localparam logic [1:0] MODE_SINGLE_READ = 2'h1;
  localparam logic [1:0] MODE_CONT_START = 2'h2;
  localparam logic [1:0] MODE_CONT_STOP = 2'h3;

  localparam logic [7:0] STOP_CONT_CODE = 8'h30;

  // ********************************
  // Targets and widths
  // ********************************
  localparam logic [2:0] TGT_CMD_STATUS = 3'h0;
  localparam logic [2:0] TGT_DATA = 3'h1;
  localparam logic [2:0] TGT_MODE = 3'h2;
  localparam logic [2:0] TGT_FILTER = 3'h3;
  localparam logic [2:0] TGT_DAC = 3'h4;
  localparam logic [2:0] TGT_OFFSET = 3'h5;
  localparam logic [2:0] TGT_GAIN = 3'h6;
  localparam logic [2:0] TGT_TEST = 3'h7;

  localparam int WORD_W = 24;
  localparam logic [4:0] BITS_BYTE = 5'h08;
  localparam logic [4:0] BITS_HALF = 5'h10;
  localparam logic [4:0] BITS_WORD = 5'h18;

  // ********************************
  // Reset values and counts
  // ********************************
  localparam logic [3:0] STATUS_RESET_HI = 4'hC;
  localparam logic [4:0] ONES_RESET_LAST = 5'h1F;
  localparam logic [2:0] SNIFF_LAST = 3'h7;
  localparam logic [23:0] WORD_ZERO = 24'h00_0000;

  typedef enum logic [1:0] {
    SRA_CMD,
    SRA_WRITE,
    SRA_READ,
    SRA_CONT
  } sra_state_e;

  typedef struct packed {
    logic [2:0] target;
    logic [23:0] data;
  } sra_wr_s;

endpackage : sra_pkg

//--- bench/sra_host.sv
// Host serial port model for the link side of the access front end
`timescale 1ns/1ps
module sra_host
(
  output logic sclk,
  output logic din,
  input wire logic dout
);
  initial
  begin
    sclk = 1'b1;
    din = 1'b0;
  end

  // ****************
  // Full-duplex transfer
  // ****************
  // Clock idles high and stands still between frames
  task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
    rx = 24'h00_0000;
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk = 1'b0;
      din = tx[i];
      #16;
      rx = {rx[22:0], dout};
      sclk = 1'b1;
      #16;
    end
    // Released line shows the inverse, so a stale level is never trusted
    din = ~din;
    // Pause lets a read word cross into the system clock
    #120;
  endtask : xfer
endmodule : sra_host

//--- bench/tb.sv
// Self-checking bench for the serial register access front end
`timescale 1ns/1ps
module tb;
  import sra_pkg::*;
  logic clk;
  logic reset;
  logic sclk;
  logic din;
  logic [7:0] status_in;
  logic [23:0] reg_read_data;
  logic dout;
  logic dout_en;
  logic wr_strobe;
  sra_wr_s wr_req;
  logic rd_strobe;
  logic [2:0] rd_target;
  logic device_reset;
  logic [23:0] rx;
  int err_count = 0;
  int checked = 0;
  int n_rd = 0;
  int n_wr = 0;
  int n_rst = 0;

  sra_serial_access i_dut (
    .clk(clk),
    .reset(reset),
    .sclk(sclk),
    .din(din),
    .status_in(status_in),
    .reg_read_data(reg_read_data),
    .dout(dout),
    .dout_en(dout_en),
    .wr_strobe(wr_strobe),
    .wr_req(wr_req),
    .rd_strobe(rd_strobe),
    .rd_target(rd_target),
    .device_reset(device_reset)
  );

  sra_host i_host (
    .sclk(sclk),
    .din(din),
    .dout(dout)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************
  // System side model and helpers
  // ****************
  function automatic logic [23:0] pat(input logic [2:0] t);
    return 24'h5A_C300 | {21'h00_0000, t};
  endfunction : pat

  function automatic logic [23:0] mask(input logic [2:0] t);
    case (t)
      TGT_CMD_STATUS, TGT_DAC: return 24'h00_00FF;
      TGT_MODE: return 24'h00_FFFF;
      default: return 24'hFF_FFFF;
    endcase
  endfunction : mask

  always @(negedge clk)
    reg_read_data <= pat(rd_target);

  // Strobes are counted mid-cycle, where they have settled
  always @(negedge clk)
  begin
    if (rd_strobe === 1'b1)
      n_rd++;
    if (wr_strobe === 1'b1)
      n_wr++;
    if (device_reset === 1'b1)
      n_rst++;
  end

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Ones before the byte keep the gate waiting and prove the last access ended
  task automatic cmd(input logic [7:0] c);
    i_host.xfer(24'h00_000F, 4, rx);
    chk("dout_en idle", 24'h00_0000, 24'(dout_en));
    i_host.xfer({16'h0000, c}, 8, rx);
  endtask : cmd

  // ****************
  // Scenarios
  // ****************
  task automatic s_status();
    int n0;
    int n1;
    n0 = n_rd;
    n1 = n_wr;
    cmd(8'h30);
    cmd(8'h00);
    cmd(8'h10);
    i_host.xfer(24'h00_0000, 8, rx);
    chk("cmd write no word", 24'(n1), 24'(n_wr));
    chk("status byte", {16'h0000, status_in}, rx);
    chk("status no fetch", 24'(n0), 24'(n_rd));
  endtask : s_status

  task automatic s_reads();
    int n0;
    for (int t = 1; t < 8; t++)
    begin
      n0 = n_rd;
      cmd(8'h10 | 8'(t));
      i_host.xfer(24'h00_0000, $countones(mask(3'(t))), rx);
      chk("rd count", 24'(n0 + 1), 24'(n_rd));
      chk("read word", pat(3'(t)) & mask(3'(t)), rx);
      chk("rd_target", 24'(t), 24'(rd_target));
    end
  endtask : s_reads

  task automatic s_writes();
    logic [23:0] tx;
    int n0;
    for (int t = 1; t < 8; t++)
    begin
      tx = (24'h9E_1F6B ^ 24'(t << 5)) & mask(3'(t));
      n0 = n_wr;
      cmd(8'(t));
      i_host.xfer(tx, $countones(mask(3'(t))), rx);
      chk("wr count", 24'(n0 + 1), 24'(n_wr));
      chk("wr target", 24'(t), 24'(wr_req.target));
      chk("wr data", tx, wr_req.data);
    end
  endtask : s_writes

  // Din held low except a near-miss stop code; stop lands on a byte boundary
  task automatic s_cont();
    cmd(8'h21);
    for (int k = 0; k < 3; k++)
    begin
      i_host.xfer((k == 1) ? 24'h31_0000 : 24'h00_0000, 24, rx);
      chk("cont word", pat(TGT_DATA), rx);
      chk("cont dout_en", 24'h00_0001, 24'(dout_en));
    end
    i_host.xfer(24'h00_0030, 8, rx);
    cmd(8'h12);
    i_host.xfer(24'h00_0000, 16, rx);
    chk("read after stop", pat(TGT_MODE) & mask(TGT_MODE), rx);
  endtask : s_cont

  task automatic s_ones();
    int n0;
    n0 = n_rst;
    cmd(8'h20);
    for (int k = 0; k < 4; k++)
    begin
      i_host.xfer(24'h00_00FF, 8, rx);
      chk("cont status", {16'h0000, status_in}, rx);
    end
    chk("ones reset", 24'(n0 + 1), 24'(n_rst));
    cmd(8'h11);
    i_host.xfer(24'h00_0000, 24, rx);
    chk("read after ones", pat(TGT_DATA), rx);
  endtask : s_ones

  task automatic final_report();
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  initial
  begin
    #200us;
    err_count++;
    final_report();
  end

  initial
  begin
    reset = 1'b1;
    status_in = 8'hC6;
    // Link logic leaves reset only after several serial clocks
    i_host.xfer(24'h00_00FF, 8, rx);
    @(negedge clk);
    reset = 1'b0;
    chk("dout_en after reset", 24'h00_0000, 24'(dout_en));
    s_status();
    s_reads();
    s_writes();
    s_cont();
    s_ones();
    final_report();
  end
endmodule : tb
